// [design/uefc_top.sv]
// enhanced flow control and fifo monitor of one uart channel
`timescale 1ns/1ps
`include "uefc_cfg.svh"
module uefc_top (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic [4:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire uefc_pkg::uefc_fifo_ev_t tx_fifo_ev,
  input  wire logic                    rx_fifo_pop,
  input  wire uefc_pkg::uefc_char_t    rx_char,
  output uefc_pkg::uefc_char_t         rx_fifo_wr,
  input  wire logic                    cts_n,
  input  wire logic                    dsr_n,
  input  wire logic [3:0]              line_levels,
  output logic                         tx_halt,
  output uefc_pkg::uefc_char_t         tx_ctl,
  input  wire logic                    tx_ctl_ready,
  output logic                         rts_n,
  output logic                         dtr_n,
  output logic                         tx_trig_irq,
  output logic                         rx_trig_irq,
  output logic                         flow_irq
);
  import uefc_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] dll_r, dlm_r, dld_r;   // divisor bytes, stored only
  logic [7:0] ier_r, fcr_r, mcr_r;   // enable, fifo, modem control
  logic [7:0] msr_r, spr_r, feature_control_reg_r;  // mode, scratch, feature
  logic [7:0] efr_r;                 // enhanced feature control
  logic [7:0] tx_fifo_threshold_r, rx_fifo_threshold_r;      // fifo thresholds
  logic [7:0] pause_char_one_r, pause_char_two_r;      // pause characters
  logic [7:0] resume_char_one_r, resume_char_two_r;        // resume characters
  logic [1:0] isr_r, isr_nxt;        // flow and special sticky bits
  logic [3:0] flow_char_status_r, flow_char_status_nxt;    // last control char flags
  logic [6:0] tx_lvl_r, rx_lvl_r;    // fifo levels
  logic       strap_done_r;          // strap captured after reset
  logic       flow_hi_r;             // receive fifo above upper level
  logic       rx_paused_r;           // remote asked us to pause
  logic       paused_sent_r;         // last control char we sent
  logic       kind_r;                // sending pause when high
  logic [1:0] half_r;                // first half of a pair seen
  logic [7:0] rdata_r, rd_val;       // read data path
  uefc_txst_t st_r, st_nxt;          // control char sender
  uefc_char_t fifo_wr_r;             // registered fifo write

  //////////////////////////////////////////////////////////////////////
  // write decode
  wire wr     = ce & reg_wr;
  wire enh_ok = efr_r[`UEFC_EFR_ENH];
  wire rd_xch = ce & reg_rd & (reg_addr == `UEFC_A_FLOW_CHAR_STATUS);

  // keep protected bits unless the enhanced enable is set
  function automatic logic [7:0] gate(input logic [7:0] old_v,
                                      input logic [7:0] new_v,
                                      input logic [7:0] mask,
                                      input logic       ok);
    logic [7:0] keep;
    keep = ok ? 8'h00 : mask;
    gate = (old_v & keep) | (new_v & ~keep);
  endfunction

  // hysteresis in characters per code, table d only
  function automatic logic [7:0] hyst(input logic [3:0] c);
    case (c)
      4'h0: hyst = 8'd0;
      4'h1: hyst = 8'd4;
      4'h2: hyst = 8'd6;
      4'h3: hyst = 8'd8;
      4'h4: hyst = 8'd8;
      4'h5: hyst = 8'd16;
      4'h6: hyst = 8'd24;
      4'h7: hyst = 8'd32;
      4'h8: hyst = 8'd40;
      4'h9: hyst = 8'd44;
      4'ha: hyst = 8'd48;
      4'hb: hyst = 8'd52;
      4'hc: hyst = 8'd12;
      4'hd: hyst = 8'd20;
      4'he: hyst = 8'd28;
      default: hyst = 8'd36;
    endcase
  endfunction

  // level step with saturation at both ends
  function automatic logic [6:0] step(input logic [6:0] l,
                                      input logic       inc,
                                      input logic       dec);
    logic up, dn;
    up = inc & (l != `UEFC_DEPTH);
    dn = dec & (l != 7'd0);
    if (up & ~dn) begin
      step = l + 7'd1;
    end else if (dn & ~up) begin
      step = l - 7'd1;
    end else begin
      step = l;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dll_r <= `UEFC_RST_DLL;
      dlm_r <= 8'h00;
      dld_r <= 8'h00;
      ier_r <= 8'h00;
      fcr_r <= 8'h00;
      mcr_r <= 8'h00;
      msr_r <= 8'h00;
      spr_r <= `UEFC_RST_SPR;
      feature_control_reg_r <= 8'h00;
      efr_r <= 8'h00;
      tx_fifo_threshold_r <= 8'h00;
      rx_fifo_threshold_r <= 8'h00;
      pause_char_one_r <= 8'h00;
      pause_char_two_r <= 8'h00;
      resume_char_one_r <= 8'h00;
      resume_char_two_r <= 8'h00;
      strap_done_r <= 1'b0;
    end else if (ce) begin
      // input levels caught on the first enabled edge after reset
      if (!strap_done_r) begin
        msr_r[7:4] <= line_levels;
        strap_done_r <= 1'b1;
      end else if (wr) begin
        case (reg_addr)
          `UEFC_A_DLL: dll_r <= reg_wdata;
          `UEFC_A_DLM: dlm_r <= reg_wdata;
          `UEFC_A_DLD: dld_r <= reg_wdata;
          `UEFC_A_IER: ier_r <= gate(ier_r, reg_wdata, `UEFC_ENH_IER, enh_ok);
          `UEFC_A_FCR: fcr_r <= gate(fcr_r, reg_wdata, `UEFC_ENH_FCR, enh_ok);
          `UEFC_A_MCR: mcr_r <= gate(mcr_r, reg_wdata, `UEFC_ENH_MCR, enh_ok);
          `UEFC_A_MSR: msr_r <= gate(msr_r, reg_wdata, `UEFC_ENH_MSR, enh_ok);
          `UEFC_A_SPR: spr_r <= reg_wdata;
          `UEFC_A_FEATURE_CONTROL_REG: feature_control_reg_r <= reg_wdata;
          `UEFC_A_EFR: efr_r <= reg_wdata;
          `UEFC_A_TX_FIFO_THRESHOLD: tx_fifo_threshold_r <= reg_wdata;
          `UEFC_A_RX_FIFO_THRESHOLD: rx_fifo_threshold_r <= reg_wdata;
          `UEFC_A_PAUSE_CHAR_ONE: pause_char_one_r <= reg_wdata;
          `UEFC_A_PAUSE_CHAR_TWO: pause_char_two_r <= reg_wdata;
          `UEFC_A_RESUME_CHAR_ONE: resume_char_one_r <= reg_wdata;
          `UEFC_A_RESUME_CHAR_TWO: resume_char_two_r <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receive character compare
  wire [1:0] rx_mode = efr_r[1:0];
  wire [1:0] tx_mode = efr_r[3:2];
  wire m1on  = rx_char.data == resume_char_one_r;
  wire m1off = rx_char.data == pause_char_one_r;
  wire m2on  = rx_char.data == resume_char_two_r;
  wire m2off = rx_char.data == pause_char_two_r;
  // both-pair mode when transmit uses both pairs or none
  wire pair  = (rx_mode == 2'b11) & (tx_mode[1] == tx_mode[0]);
  wire any   = (rx_mode == 2'b11) & ~pair;
  wire hit_on  = (rx_mode == 2'b10 & m1on) | (rx_mode == 2'b01 & m2on)
               | (any & (m1on | m2on)) | (pair & half_r[1] & m2on);
  wire hit_off = (rx_mode == 2'b10 & m1off) | (rx_mode == 2'b01 & m2off)
               | (any & (m1off | m2off)) | (pair & half_r[0] & m2off);
  wire rx_ev   = ce & rx_char.valid;
  wire rx_on   = rx_ev & hit_on;
  wire rx_off  = rx_ev & hit_off;
  wire special = rx_ev & efr_r[`UEFC_EFR_SPC] & m2off;
  // matched flow characters never reach the fifo, except the first char of a pair in pair mode
  wire fifo_push = rx_char.valid & ~hit_on & ~hit_off
                 & ~msr_r[`UEFC_MSR_RXOFF];

  // receive side state: pair tracking, remote pause, fifo write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_r <= 2'b00;
      rx_paused_r <= 1'b0;
      fifo_wr_r <= '0;
    end else if (ce) begin
      fifo_wr_r.valid <= fifo_push;
      fifo_wr_r.data <= rx_char.data;
      if (rx_char.valid) begin
        half_r <= {pair & m1on, pair & m1off};
      end
      if (rx_mode == 2'b00) begin
        rx_paused_r <= 1'b0;
      end else if (rx_off) begin
        rx_paused_r <= 1'b1;
      end else if (rx_on) begin
        rx_paused_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // fifo levels, thresholds and handshake watermark
  wire [7:0] rx_lvl = {1'b0, rx_lvl_r};
  wire [7:0] tx_lvl = {1'b0, tx_lvl_r};
  wire       tbl_d  = feature_control_reg_r[7:6] == `UEFC_TABLE_D;
  wire [7:0] hy     = tbl_d ? hyst(feature_control_reg_r[3:0]) : `UEFC_STEP;
  wire [7:0] upper  = rx_fifo_threshold_r + hy;
  wire [7:0] lower  = (rx_fifo_threshold_r > hy) ? rx_fifo_threshold_r - hy : 8'h00;
  wire       trg_on = rx_fifo_threshold_r != 8'h00;

  assign tx_trig_irq = tx_lvl < tx_fifo_threshold_r;
  assign rx_trig_irq = trg_on & (rx_lvl >= rx_fifo_threshold_r);

  // level counters and the watermark flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_lvl_r <= 7'd0;
      rx_lvl_r <= 7'd0;
      flow_hi_r <= 1'b0;
    end else if (ce) begin
      tx_lvl_r <= step(tx_lvl_r, tx_fifo_ev.push, tx_fifo_ev.pop);
      rx_lvl_r <= step(rx_lvl_r, fifo_wr_r.valid, rx_fifo_pop);
      if (trg_on & (rx_lvl >= upper)) begin
        flow_hi_r <= 1'b1;
      end else if (rx_lvl < lower) begin
        flow_hi_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // hardware handshake pins
  wire sel_dsr = mcr_r[`UEFC_MCR_SEL];
  wire auto_hi = efr_r[`UEFC_EFR_RTS] & flow_hi_r;
  // modem bit low keeps the pin high, as after reset
  assign rts_n = ~mcr_r[`UEFC_MCR_RTS] | (auto_hi & ~sel_dsr);
  assign dtr_n = ~mcr_r[`UEFC_MCR_DTR] | (auto_hi & sel_dsr);
  wire hs_in   = sel_dsr ? dsr_n : cts_n;
  // the shifter finishes its current character before obeying
  assign tx_halt = (efr_r[`UEFC_EFR_CTS] & hs_in) | rx_paused_r
                 | msr_r[`UEFC_MSR_TXOFF];

  //////////////////////////////////////////////////////////////////////
  // control character sender
  wire last_ok = tx_ctl_ready & ((st_r == TX_FIRST & tx_mode != 2'b11)
               | st_r == TX_SECOND);
  wire tx_done = ce & last_ok;
  wire [7:0] ch_one = tx_mode[1] ? (kind_r ? pause_char_one_r : resume_char_one_r)
                                 : (kind_r ? pause_char_two_r : resume_char_two_r);
  wire [7:0] ch_two = kind_r ? pause_char_two_r : resume_char_two_r;
  wire want = (tx_mode != 2'b00) & (flow_hi_r != paused_sent_r);

  // next state of the sender
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      TX_IDLE: if (want) st_nxt = TX_FIRST;
      TX_FIRST: if (tx_ctl_ready) st_nxt = (tx_mode == 2'b11) ?
                                          TX_SECOND : TX_IDLE;
      TX_SECOND: if (tx_ctl_ready) st_nxt = TX_IDLE;
      default: st_nxt = TX_IDLE;
    endcase
  end

  // sender registers and the character offered to the shifter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= TX_IDLE;
      kind_r <= 1'b0;
      paused_sent_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      if (st_r == TX_IDLE & want) begin
        kind_r <= flow_hi_r;
      end
      if (tx_mode == 2'b00) begin
        paused_sent_r <= flow_hi_r;
      end else if (last_ok) begin
        paused_sent_r <= kind_r;
      end
    end
  end
  assign tx_ctl = '{valid: st_r != TX_IDLE,
                    data: (st_r == TX_SECOND) ? ch_two : ch_one};

  //////////////////////////////////////////////////////////////////////
  // sticky status: set wins over clear
  wire isr_wr = wr & enh_ok & (reg_addr == `UEFC_A_ISR);
  assign isr_nxt = (isr_wr ? reg_wdata[5:4] : isr_r)
                 | {rx_on | rx_off, special};
  wire [3:0] xc_base = rd_xch ? 4'h0 : flow_char_status_r;
  wire tx_on_d  = tx_done & ~kind_r;
  wire tx_off_d = tx_done & kind_r;
  assign flow_char_status_nxt = (efr_r[3:0] == 4'h0) ? 4'h0 :
    {tx_on_d | (xc_base[3] & ~tx_off_d), tx_off_d | (xc_base[2] & ~tx_on_d),
     rx_on | (xc_base[1] & ~rx_off), rx_off | (xc_base[0] & ~rx_on)};
  assign flow_irq = isr_r != 2'b00;

  // status registers and read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      isr_r <= 2'b00;
      flow_char_status_r <= 4'h0;
      rdata_r <= 8'h00;
    end else if (ce) begin
      isr_r <= isr_nxt;
      flow_char_status_r <= flow_char_status_nxt;
      rdata_r <= reg_rd ? rd_val : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux, write-only and unmapped offsets read zero
  wire pend = tx_trig_irq | rx_trig_irq | flow_irq;
  wire [7:0] lsr_v = (tx_lvl_r == 7'd0) ? `UEFC_LSR_EMPTY : 8'h00;
  always_comb begin
    case (reg_addr)
      `UEFC_A_DLL: rd_val = dll_r;
      `UEFC_A_DLM: rd_val = dlm_r;
      `UEFC_A_DLD: rd_val = dld_r;
      `UEFC_A_IER: rd_val = ier_r;
      `UEFC_A_ISR: rd_val = {2'b00, isr_r, 1'b0, rx_trig_irq,
                             tx_trig_irq, ~pend};
      `UEFC_A_FCR: rd_val = fcr_r;
      `UEFC_A_MCR: rd_val = mcr_r;
      `UEFC_A_LSR: rd_val = lsr_v;
      `UEFC_A_MSR: rd_val = msr_r;
      `UEFC_A_SPR: rd_val = spr_r;
      `UEFC_A_FEATURE_CONTROL_REG: rd_val = feature_control_reg_r;
      `UEFC_A_EFR: rd_val = efr_r;
      `UEFC_A_TX_FIFO_LEVEL: rd_val = tx_lvl;
      `UEFC_A_RX_FIFO_LEVEL: rd_val = rx_lvl;
      `UEFC_A_FLOW_CHAR_STATUS: rd_val = {4'h0, flow_char_status_r};
      default: rd_val = 8'h00;
    endcase
  end
  assign reg_rdata = rdata_r;
  assign rx_fifo_wr = fifo_wr_r;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cts_halts_tx: assert property (
    efr_r[7] & ~sel_dsr & cts_n |-> tx_halt)
    else $error("cts high did not halt transmitter");
  a_rts_plain_out: assert property (
    ~efr_r[6] |-> rts_n == ~mcr_r[1] && dtr_n == ~mcr_r[0])
    else $error("handshake pin not following modem bit");
  a_rts_auto_high: assert property (
    ce & efr_r[6] & mcr_r[1] & ~sel_dsr & trg_on & (rx_lvl >= upper)
    |=> rts_n)
    else $error("rts not raised at upper level");
  a_enh_write_lock: assert property (
    ce & reg_wr & (reg_addr == `UEFC_A_MCR) & ~efr_r[4] & strap_done_r
    |=> mcr_r[7:5] == $past(mcr_r[7:5]) && mcr_r[3:2] == $past(mcr_r[3:2]))
    else $error("protected modem bits changed while locked");
  a_flow_char_status_off_zero: assert property (
    ce & (efr_r[3:0] == 4'h0) |=> flow_char_status_r == 4'h0)
    else $error("flow status not zero with flow control off");
  a_flow_char_status_rd_clr: assert property (
    rd_xch & ~tx_done & ~rx_on & ~rx_off |=> flow_char_status_r == 4'h0)
    else $error("flow status not cleared by read");
  a_special_flag: assert property (
    special |=> isr_r[0] ##1 (rdata_r[4] || !$past(reg_rd, 1)
                              || $past(reg_addr) != `UEFC_A_ISR))
    else $error("special character flag not set");
  a_pause_two_held: assert property (
    ce & rx_char.valid & (rx_mode == 2'b01) & m2off |=> ~rx_fifo_wr.valid)
    else $error("pause char two entered fifo");
  a_rd_latency: assert property (
    ce & reg_rd & (reg_addr == `UEFC_A_RX_FIFO_LEVEL) |=> reg_rdata == $past(rx_lvl))
    else $error("receive level read data wrong");
  a_level_bound: assert property (
    tx_lvl_r <= `UEFC_DEPTH && rx_lvl_r <= `UEFC_DEPTH)
    else $error("fifo level above depth");

  c_pair_sent: cover property (st_r == TX_FIRST ##[1:8] st_r == TX_SECOND);
  c_remote_pause: cover property (rx_off ##[1:50] rx_on);
  c_rts_cycle: cover property ($rose(flow_hi_r) ##[1:200] $fell(flow_hi_r));
endmodule

// [design/uefc_cfg.svh]
// offsets, field positions, reset values and limits of the flow block
`ifndef UEFC_CFG_SVH
`define UEFC_CFG_SVH
// register offsets on the 5-bit register port
`define UEFC_A_DLL   5'h00
`define UEFC_A_DLM   5'h01
`define UEFC_A_DLD   5'h02
`define UEFC_A_IER   5'h03
`define UEFC_A_ISR   5'h04
`define UEFC_A_FCR   5'h05
`define UEFC_A_MCR   5'h06
`define UEFC_A_LSR   5'h07
`define UEFC_A_MSR   5'h08
`define UEFC_A_SPR   5'h09
`define UEFC_A_FEATURE_CONTROL_REG  5'h0a
`define UEFC_A_EFR   5'h0b
`define UEFC_A_TX_FIFO_LEVEL 5'h0c
`define UEFC_A_TX_FIFO_THRESHOLD 5'h0d
`define UEFC_A_RX_FIFO_LEVEL 5'h0e
`define UEFC_A_RX_FIFO_THRESHOLD 5'h0f
`define UEFC_A_PAUSE_CHAR_ONE 5'h10
`define UEFC_A_PAUSE_CHAR_TWO 5'h11
`define UEFC_A_RESUME_CHAR_ONE  5'h12
`define UEFC_A_RESUME_CHAR_TWO  5'h13
`define UEFC_A_FLOW_CHAR_STATUS 5'h14
// reset values that differ from zero
`define UEFC_RST_DLL 8'h01
`define UEFC_RST_SPR 8'hff
`define UEFC_LSR_EMPTY 8'h60
// write-protected enhanced bits per register
`define UEFC_ENH_IER 8'he0
`define UEFC_ENH_ISR 8'h30
`define UEFC_ENH_FCR 8'h30
`define UEFC_ENH_MCR 8'hec
`define UEFC_ENH_MSR 8'hfc
// field positions
`define UEFC_EFR_CTS 7
`define UEFC_EFR_RTS 6
`define UEFC_EFR_SPC 5
`define UEFC_EFR_ENH 4
`define UEFC_MCR_DTR 0
`define UEFC_MCR_RTS 1
`define UEFC_MCR_SEL 2
`define UEFC_MSR_TXOFF 3
`define UEFC_MSR_RXOFF 2
// fifo depth and the fixed next-level step
`define UEFC_DEPTH 7'd64
`define UEFC_STEP 8'h04
`define UEFC_TABLE_D 2'b11
`endif

// [design/uefc_pkg.sv]
// types shared by the flow block and its bench
package uefc_pkg;
  // control character sender states
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_FIRST,
    TX_SECOND
  } uefc_txst_t;
  // one character with its valid flag
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uefc_char_t;
  // transmit fifo push and pop events
  typedef struct packed {
    logic push;
    logic pop;
  } uefc_fifo_ev_t;
endpackage

// [sim/uefc_remote.sv]
// remote serial device model: handshake lines, rx chars, ctl char sink
`timescale 1ns/1ps
module uefc_remote (
  input  wire logic                 clk,
  input  wire logic                 stop_cts,
  input  wire logic                 stop_dsr,
  input  wire logic [1:0]           slow,
  input  wire uefc_pkg::uefc_char_t tx_ctl,
  output logic                      cts_n,
  output logic                      dsr_n,
  output logic                      tx_ctl_ready,
  output uefc_pkg::uefc_char_t      rx_char
);
  import uefc_pkg::*;
  logic [7:0] got[$];    // control chars taken from the line
  int         wait_cnt;  // cycles the current offer has waited
  initial begin
    rx_char = '0;
    tx_ctl_ready = 1'b0;
    wait_cnt = 0;
  end
  // remote raises its stop request on either handshake line
  assign cts_n = stop_cts;
  assign dsr_n = stop_dsr;
  // take an offered char only after slow cycles, like a busy peer
  always @(posedge clk) begin
    if (tx_ctl_ready && tx_ctl.valid) begin
      got.push_back(tx_ctl.data);
      tx_ctl_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_ctl.valid) begin
      wait_cnt <= wait_cnt + 1;
      tx_ctl_ready <= (wait_cnt >= slow);
    end
  end
  // one char pulse; data goes stale-inverted once valid drops
  task automatic send(input logic [7:0] d);
    @(posedge clk);
    rx_char <= '{valid: 1'b1, data: d};
    @(posedge clk);
    rx_char <= '{valid: 1'b0, data: ~d};
  endtask
endmodule

// [sim/testbench.sv]
// self-checking bench of the enhanced flow block
`timescale 1ns/1ps
`include "uefc_cfg.svh"
module testbench;
  import uefc_pkg::*;
  logic          clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [4:0]    reg_addr = '0;
  logic [7:0]    reg_wdata = '0, reg_rdata;
  logic          reg_wr = 1'b0, reg_rd = 1'b0, rx_fifo_pop = 1'b0;
  uefc_fifo_ev_t tx_fifo_ev = '0;
  uefc_char_t    rx_char, rx_fifo_wr, tx_ctl;
  logic          cts_n, dsr_n, tx_halt, tx_ctl_ready, rts_n, dtr_n;
  logic          tx_trig_irq, rx_trig_irq, flow_irq;
  logic [3:0]    line_levels = '0;
  logic          stop_cts = 1'b0, stop_dsr = 1'b0;
  logic [1:0]    slow = 2'd0;
  logic [7:0]    last_wr = '0;  // last char the fifo took
  int            err_count = 0, check_count = 0, stored = 0, n;
  logic [12:0]   rv[12];  // offset and reset value pairs
  logic [7:0]    fc[4] = '{8'h13, 8'h93, 8'h11, 8'h91};
  uefc_top uut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_fifo_ev(tx_fifo_ev),
    .rx_fifo_pop(rx_fifo_pop), .rx_char(rx_char), .rx_fifo_wr(rx_fifo_wr),
    .cts_n(cts_n), .dsr_n(dsr_n), .line_levels(line_levels),
    .tx_halt(tx_halt), .tx_ctl(tx_ctl), .tx_ctl_ready(tx_ctl_ready),
    .rts_n(rts_n), .dtr_n(dtr_n), .tx_trig_irq(tx_trig_irq),
    .rx_trig_irq(rx_trig_irq), .flow_irq(flow_irq));
  uefc_remote remote (.clk(clk), .stop_cts(stop_cts), .stop_dsr(stop_dsr),
    .slow(slow), .tx_ctl(tx_ctl), .cts_n(cts_n), .dsr_n(dsr_n),
    .tx_ctl_ready(tx_ctl_ready), .rx_char(rx_char));
  initial forever #10 clk = ~clk;
  // model of the receive fifo: count every stored char
  always @(posedge clk) begin
    if (rx_fifo_wr.valid === 1'b1) begin
      stored <= stored + 1;
      last_wr <= rx_fifo_wr.data;
    end
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // 0 tx push, 1 tx pop, 2 rx pop
  task automatic evt(input int k);
    @(posedge clk);
    if (k == 2) rx_fifo_pop <= 1'b1;
    else tx_fifo_ev <= (k == 0) ? 2'b10 : 2'b01;
    @(posedge clk);
    rx_fifo_pop <= 1'b0;
    tx_fifo_ev <= '0;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wait_got(input int k);
    for (int j = 0; j < 100; j++) if (remote.got.size() < k) @(posedge clk);
    chk(8'(remote.got.size()), 8'(k));
    if (remote.got.size() < k) wrap_up();
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
  initial begin
    void'($urandom(22386));
    line_levels = 4'($urandom);
    rv = '{{`UEFC_A_DLL, 8'h01}, {`UEFC_A_DLM, 8'h00}, {`UEFC_A_ISR, 8'h01},
      {`UEFC_A_LSR, 8'h60}, {`UEFC_A_SPR, 8'hff}, {`UEFC_A_EFR, 8'h00},
      {`UEFC_A_TX_FIFO_LEVEL, 8'h00}, {`UEFC_A_RX_FIFO_LEVEL, 8'h00}, {`UEFC_A_MCR, 8'h00},
      {`UEFC_A_FLOW_CHAR_STATUS, 8'h00}, {`UEFC_A_TX_FIFO_THRESHOLD, 8'h00}, {5'h1f, 8'h00}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (rv[k]) rd_chk(rv[k][12:8], rv[k][7:0]);
    rd_chk(`UEFC_A_MSR, {line_levels, 4'h0});
    chk({6'h0, rts_n, dtr_n}, 8'h03);
    // a write while the clock enable is low is lost
    @(posedge clk);
    ce <= 1'b0;
    wr(`UEFC_A_SPR, 8'h5a);
    ce <= 1'b1;
    rd_chk(`UEFC_A_SPR, 8'hff);
    // protected bits hold while the enable is clear
    wr(`UEFC_A_MCR, 8'hff);
    rd_chk(`UEFC_A_MCR, 8'h13);
    #1 chk({6'h0, rts_n, dtr_n}, 8'h00);
    wr(`UEFC_A_EFR, 8'h10);
    wr(`UEFC_A_MCR, 8'hff);
    rd_chk(`UEFC_A_MCR, 8'hff);
    // transmit gating by the selected handshake input
    wr(`UEFC_A_EFR, 8'h90);
    for (int s = 0; s < 2; s++) begin
      wr(`UEFC_A_MCR, {5'h00, 1'(s), 2'b11});
      stop_cts <= (s == 0);
      stop_dsr <= (s == 1);
      settle();
      chk({7'h0, tx_halt}, 8'h01);
      stop_cts <= (s == 1);
      stop_dsr <= (s == 0);
      settle();
      chk({7'h0, tx_halt}, 8'h00);
    end
    stop_cts <= 1'b0;
    stop_dsr <= 1'b0;
    // transmit level and threshold
    n = $urandom_range(40, 2);
    repeat (n) evt(0);
    evt(1);
    rd_chk(`UEFC_A_TX_FIFO_LEVEL, 8'(n - 1));
    wr(`UEFC_A_TX_FIFO_THRESHOLD, 8'(n));
    #1 chk({7'h0, tx_trig_irq}, 8'h01);
    evt(0);
    #1 chk({7'h0, tx_trig_irq}, 8'h00);
    // receive watermark, table d with six chars of hysteresis
    slow <= 2'd2;
    wr(`UEFC_A_MCR, 8'h03);
    wr(`UEFC_A_EFR, 8'h5c);
    wr(`UEFC_A_RX_FIFO_THRESHOLD, 8'h08);
    wr(`UEFC_A_FEATURE_CONTROL_REG, 8'hc2);
    for (int k = 0; k < 4; k++) wr(5'(`UEFC_A_PAUSE_CHAR_ONE + k), fc[k]);
    repeat (8) remote.send(8'($urandom));
    settle();
    chk({6'h0, rx_trig_irq, rts_n}, 8'h02);
    rd_chk(`UEFC_A_RX_FIFO_LEVEL, 8'h08);
    repeat (4) remote.send(8'($urandom));
    settle();
    chk({7'h0, rts_n}, 8'h00);
    repeat (2) remote.send(8'($urandom));
    settle();
    chk({7'h0, rts_n}, 8'h01);
    wait_got(2);
    chk(remote.got[0], fc[0]);
    chk(remote.got[1], fc[1]);
    rd_chk(`UEFC_A_FLOW_CHAR_STATUS, 8'h04);
    rd_chk(`UEFC_A_FLOW_CHAR_STATUS, 8'h00);
    repeat (12) evt(2);
    settle();
    chk({7'h0, rts_n}, 8'h01);
    evt(2);
    settle();
    chk({7'h0, rts_n}, 8'h00);
    rd_chk(`UEFC_A_RX_FIFO_LEVEL, 8'h01);
    wait_got(4);
    chk(remote.got[2], fc[2]);
    chk(remote.got[3], fc[3]);
    rd_chk(`UEFC_A_FLOW_CHAR_STATUS, 8'h08);
    // special char goes to the fifo and flags status
    wr(`UEFC_A_EFR, 8'h30);
    n = stored;
    remote.send(fc[1]);
    settle();
    chk(8'(stored - n), 8'h01);
    chk(last_wr, fc[1]);
    chk({7'h0, flow_irq}, 8'h01);
    // second pair compare withholds the pause char
    wr(`UEFC_A_EFR, 8'h31);
    n = stored;
    remote.send(fc[1]);
    settle();
    rd_chk(`UEFC_A_FLOW_CHAR_STATUS, 8'h01);
    remote.send(fc[1]);
    settle();
    chk(8'(stored - n), 8'h00);
    rd_chk(`UEFC_A_ISR, 8'h30);
    // pair sequence, then resume char two alone in any-char mode
    wr(`UEFC_A_EFR, 8'h13);
    n = stored;
    remote.send(fc[2]);
    remote.send(fc[3]);
    settle();
    chk(last_wr, fc[2]);
    rd_chk(`UEFC_A_FLOW_CHAR_STATUS, 8'h02);
    wr(`UEFC_A_EFR, 8'h1b);
    remote.send(fc[3]);
    settle();
    chk(8'(stored - n), 8'h01);
    rd_chk(`UEFC_A_FLOW_CHAR_STATUS, 8'h02);
    wr(`UEFC_A_EFR, 8'h10);
    rd_chk(`UEFC_A_FLOW_CHAR_STATUS, 8'h00);
    // lock the enhanced bits after programming them
    wr(`UEFC_A_MCR, 8'he7);
    wr(`UEFC_A_EFR, 8'h00);
    wr(`UEFC_A_MCR, 8'h00);
    rd_chk(`UEFC_A_MCR, 8'he4);
    wrap_up();
  end
endmodule
